// *** shared/ssp_pkg.sv ***
package ssp_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] SSP_CTRL_OFS  = 8'h00; // serial_control_one
	localparam logic [7:0] SSP_STAT_OFS  = 8'h04; // serial_status_reg
	localparam logic [7:0] SSP_BUF_OFS   = 8'h08; // transfer_buffer
	localparam logic [7:0] SSP_FLAG_OFS  = 8'h0c; // serial_interrupt_flag word

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int         SSP_SMP_POS   = 7;     // input_sample_bit in status
	localparam int         SSP_CKE_POS   = 6;     // clock edge select in status
	localparam int         SSP_BF_POS    = 0;     // buffer_full_flag in status
	localparam logic [7:0] SSP_CTRL_RST  = 8'h00;
	localparam logic [1:0] SSP_STAT_RST  = 2'h0;

	// ------------------------------------------------------------
	// mode_select_field codes
	// ------------------------------------------------------------
	localparam logic [3:0] SSP_M_DIV4    = 4'h0;
	localparam logic [3:0] SSP_M_DIV16   = 4'h1;
	localparam logic [3:0] SSP_M_DIV64   = 4'h2;
	localparam logic [3:0] SSP_M_TIMER_TWO_OUTPUT    = 4'h3;
	localparam logic [3:0] SSP_M_SLV_SS  = 4'h4;
	localparam logic [3:0] SSP_M_SLV     = 4'h5;

	// ------------------------------------------------------------
	// timing: system clock and serial clock half periods
	// ------------------------------------------------------------
	localparam int         SSP_CLK_NS    = 100;   // mclk_i period in ns
	localparam int         SSP_HALF4     = 4 / 2;  // half period, sysclk/4
	localparam int         SSP_HALF16    = 16 / 2; // half period, sysclk/16
	localparam int         SSP_HALF64    = 64 / 2; // half period, sysclk/64
	localparam int         SSP_BITS      = 8;     // bits per frame
	localparam logic [4:0] SSP_HS_LAST   = 5'h10; // extra half step for late sampling

	// control register layout
	typedef struct packed {
		logic       write_collision_flag;  // write_collision_flag
		logic       ovf;   // receive_overflow_flag
		logic       en;    // port_enable_bit
		logic       clock_polarity_bit;   // clock_polarity_bit
		logic [3:0] mode;  // mode_select_field
	} ssp_ctrl_t;

	// master engine states
	typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_t;

endpackage : ssp_pkg

// *** design/ssp_spi_port.sv ***
// Our own choices: the AHB-Lite register port and the register offsets.
module ssp_spi_port
	import ssp_pkg::*;
(
	input  wire logic        mclk_i,      // system clock, 10 MHz
	input  wire logic        nrst_i,      // async reset, active low
	input  wire logic        ce_i,        // clock enable, freezes all state
	input  wire logic        hsel_i,      // ahb-lite slave select
	input  wire logic [7:0]  haddr_i,     // ahb byte address
	input  wire logic [1:0]  htrans_i,    // ahb transfer type
	input  wire logic        hwrite_i,    // ahb write
	input  wire logic [2:0]  hsize_i,     // ahb size, word only
	input  wire logic [31:0] hwdata_i,    // ahb write data
	input  wire logic        hready_i,    // ahb bus ready
	output logic      [31:0] hrdata_o,    // ahb read data
	output logic             hreadyout_o, // ahb slave ready
	output logic             hresp_o,     // ahb response, always okay
	input  wire logic        timer_two_output_tick_i, // timer_two_output event pulse
	input  wire logic        sleep_i,     // device asleep
	input  wire logic        sck_i,       // serial clock pin level
	output logic             sck_o,       // serial clock drive
	output logic             sck_oe_o,    // serial clock drive enable
	input  wire logic        sdi_i,       // serial data in
	output logic             sdo_o,       // serial data out
	output logic             sdo_oe_o,    // serial data out drive enable
	input  wire logic        ss_n_i,      // slave select, active low
	output logic             irq_flag_o,  // serial_interrupt_flag level
	output logic             wake_o       // wake-up pulse on slave byte
);
	import ssp_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ssp_ctrl_t   ctrl_reg;     // serial_control_one
	logic        smp_reg;      // input_sample_bit
	logic        cke_reg;      // clock edge select
	logic        bf_reg;       // buffer_full_flag
	logic        sif_reg;      // serial_interrupt_flag
	logic [7:0]  rxbuf_reg;    // receive half of transfer_buffer
	logic [7:0]  shift_reg;    // transmit shift_register
	logic [7:0]  rxsr_reg;     // receive shift_register
	logic [3:0]  rxcnt_reg;    // bits sampled so far
	logic        sdo_reg;      // data out level
	logic        sck_reg;      // master clock level
	logic        sckp_reg;     // last sampled clock pin
	logic [4:0]  hs_reg;       // master half-step index
	logic [4:0]  div_reg;      // half period countdown
	ssp_state_t  st_reg;       // master engine state
	logic        wake_reg;     // wake pulse
	logic [7:0]  addr_reg;     // data phase address
	logic        dwr_reg;      // data phase write pending
	logic        drd_reg;      // data phase read pending

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	// true for the six serial personalities only
	function automatic logic is_spi(input logic [3:0] m);
		is_spi = (m <= SSP_M_SLV);
	endfunction : is_spi

	// half period in system clocks minus one, for a master rate code
	function automatic logic [4:0] half_of(input logic [3:0] m);
		case (m)
			SSP_M_DIV4:  half_of = 5'(SSP_HALF4 - 1);
			SSP_M_DIV16: half_of = 5'(SSP_HALF16 - 1);
			default:     half_of = 5'(SSP_HALF64 - 1);
		endcase
	endfunction : half_of

	logic active;      // port on and in a serial mode
	logic is_master;   // master personality
	logic is_slave;    // slave personality
	logic ss_ctl;      // slave select governs the port
	logic ss_off;      // select deasserted under control
	logic busy;        // byte in flight
	assign active    = ctrl_reg.en && is_spi(ctrl_reg.mode);
	assign is_master = active && (ctrl_reg.mode[3:2] == 2'h0);
	assign is_slave  = active && !is_master;
	assign ss_ctl    = is_slave && (ctrl_reg.mode == SSP_M_SLV_SS);
	assign ss_off    = ss_ctl && ss_n_i;
	assign busy      = is_master ? (st_reg == SSP_RUN) : (rxcnt_reg != 4'h0);

	// ------------------------------------------------------------
	// ahb-lite slave: zero wait, okay only, stalls while frozen
	// ------------------------------------------------------------
	logic take;
	assign take        = ce_i && hsel_i && hready_i && htrans_i[1];
	assign hreadyout_o = ce_i; // frozen block holds the bus off
	assign hresp_o     = 1'b0;

	// address phase capture
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			addr_reg <= 8'h00;
			dwr_reg  <= 1'b0;
			drd_reg  <= 1'b0;
		end
		else if (ce_i)
		begin
			addr_reg <= haddr_i;
			dwr_reg  <= take && hwrite_i;
			drd_reg  <= take && !hwrite_i;
		end
	end

	logic wr_ctrl;  // write to control
	logic wr_stat;  // write to status
	logic wr_buf;   // write to transfer buffer
	logic wr_flag;  // write to interrupt flag word
	logic rd_buf;   // read of transfer buffer
	assign wr_ctrl = dwr_reg && (addr_reg == SSP_CTRL_OFS);
	assign wr_stat = dwr_reg && (addr_reg == SSP_STAT_OFS);
	assign wr_buf  = dwr_reg && (addr_reg == SSP_BUF_OFS);
	assign wr_flag = dwr_reg && (addr_reg == SSP_FLAG_OFS);
	assign rd_buf  = drd_reg && (addr_reg == SSP_BUF_OFS);

	// read mux from registered state; unmapped reads return zero
	always_comb
	begin
		hrdata_o = 32'h0000_0000;
		case (addr_reg)
			SSP_CTRL_OFS: hrdata_o[7:0] = ctrl_reg;
			SSP_STAT_OFS: hrdata_o[7:0] = {smp_reg, cke_reg, 5'h00, bf_reg};
			SSP_BUF_OFS:  hrdata_o[7:0] = rxbuf_reg;
			SSP_FLAG_OFS: hrdata_o[0]   = sif_reg;
			default:      hrdata_o      = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// serial clock events
	// ------------------------------------------------------------
	logic step;      // master half step
	logic lead_ev;   // idle to active edge
	logic trail_ev;  // active to idle edge
	logic out_ev;    // output changes
	logic samp_ev;   // input captured
	logic slv_go;    // slave may shift
	logic byte_done; // eighth bit captured
	logic [7:0] rx_byte;
	logic start;     // master exchange begins
	logic coll;      // colliding buffer write

	// sleep halts the master only; the slave runs on the pin
	assign step = (st_reg == SSP_RUN) && !sleep_i &&
		((ctrl_reg.mode == SSP_M_TIMER_TWO_OUTPUT) ? timer_two_output_tick_i : (div_reg == 5'h00));
	assign slv_go = is_slave && !ss_off;

	always_comb
	begin
		lead_ev  = 1'b0;
		trail_ev = 1'b0;
		if (is_master)
		begin
			lead_ev  = step && !hs_reg[0];
			trail_ev = step && hs_reg[0];
		end
		else if (slv_go)
		begin
			lead_ev  = ((sck_i ^ ctrl_reg.clock_polarity_bit) && !(sckp_reg ^ ctrl_reg.clock_polarity_bit));
			trail_ev = (!(sck_i ^ ctrl_reg.clock_polarity_bit) && (sckp_reg ^ ctrl_reg.clock_polarity_bit));
		end
	end

	// the extra half step only exists for late sampling
	assign out_ev = (cke_reg ? trail_ev : lead_ev) && (hs_reg != SSP_HS_LAST);

	// master may sample late; slave always mid bit
	always_comb
	begin
		if (is_master && smp_reg)
			samp_ev = cke_reg ? trail_ev : (lead_ev && (hs_reg != 5'h00));
		else
			samp_ev = cke_reg ? lead_ev : trail_ev;
	end

	assign byte_done = samp_ev && (rxcnt_reg == 4'(SSP_BITS - 1));
	assign rx_byte   = {rxsr_reg[6:0], sdi_i};
	assign coll      = wr_buf && busy;
	assign start     = wr_buf && !busy && is_master;

	// ------------------------------------------------------------
	// control and status registers
	// ------------------------------------------------------------
	// flags: writing zero clears, hardware set wins
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ctrl_reg <= SSP_CTRL_RST;
		else if (ce_i)
		begin
			if (wr_ctrl)
			begin
				ctrl_reg      <= hwdata_i[7:0];
				ctrl_reg.write_collision_flag <= ctrl_reg.write_collision_flag & hwdata_i[7];
				ctrl_reg.ovf  <= ctrl_reg.ovf & hwdata_i[6];
			end
			if (coll)
				ctrl_reg.write_collision_flag <= 1'b1;
			if (byte_done && is_slave && bf_reg)
				ctrl_reg.ovf <= 1'b1;
		end
	end

	// status bits: sample and edge bits are writable
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			{smp_reg, cke_reg} <= SSP_STAT_RST;
		else if (ce_i && wr_stat)
			{smp_reg, cke_reg} <= {hwdata_i[SSP_SMP_POS], hwdata_i[SSP_CKE_POS]};
	end

	// receive buffer, full flag and interrupt flag
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rxbuf_reg <= 8'h00;
			bf_reg    <= 1'b0;
			sif_reg   <= 1'b0;
		end
		else if (ce_i)
		begin
			if (rd_buf)
				bf_reg <= 1'b0;
			if (wr_flag && !hwdata_i[0])
				sif_reg <= 1'b0;
			// overrun keeps the old byte, every other completion lands
			if (byte_done && !(is_slave && bf_reg))
			begin
				rxbuf_reg <= rx_byte;
				bf_reg    <= 1'b1;
				sif_reg   <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// shift engine
	// ------------------------------------------------------------
	// transmit side: loaded only through the buffer address
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			shift_reg <= 8'h00;
			sdo_reg   <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wr_buf && !busy)
			begin
				shift_reg <= hwdata_i[7:0];
				if (cke_reg)
					sdo_reg <= hwdata_i[7];
			end
			else if (out_ev)
			begin
				shift_reg <= {shift_reg[6:0], 1'b0};
				sdo_reg   <= cke_reg ? shift_reg[6] : shift_reg[7];
			end
		end
	end

	// receive side: bit counter cleared by select, disable, reset
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rxsr_reg  <= 8'h00;
			rxcnt_reg <= 4'h0;
		end
		else if (ce_i)
		begin
			if (!active || ss_off)
				rxcnt_reg <= 4'h0;
			else if (byte_done)
				rxcnt_reg <= 4'h0;
			else if (samp_ev)
			begin
				rxsr_reg  <= rx_byte;
				rxcnt_reg <= rxcnt_reg + 4'h1;
			end
		end
	end

	// last half step of a frame: the clock always gets all sixteen toggles,
	// so the far end sees its eighth edge even when we sampled on the first
	logic [4:0] hs_end;
	assign hs_end = (smp_reg && !cke_reg) ? SSP_HS_LAST : 5'(2 * SSP_BITS - 1);

	// master sequencer: sixteen toggles, optional late half step
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg  <= SSP_IDLE;
			hs_reg  <= 5'h00;
			div_reg <= 5'h00;
			sck_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			case (st_reg)
				SSP_IDLE:
				begin
					sck_reg <= ctrl_reg.clock_polarity_bit;
					hs_reg  <= 5'h00;
					div_reg <= half_of(ctrl_reg.mode);
					if (start)
						st_reg <= SSP_RUN;
				end
				SSP_RUN:
				begin
					if (!is_master)
						st_reg <= SSP_IDLE;
					else if (step)
					begin
						if (hs_reg != SSP_HS_LAST)
							sck_reg <= !sck_reg;
						hs_reg  <= hs_reg + 5'h01;
						div_reg <= half_of(ctrl_reg.mode);
						if (hs_reg == hs_end)
							st_reg <= SSP_IDLE;
					end
					else if (!sleep_i && (div_reg != 5'h00))
						div_reg <= div_reg - 5'h01;
				end
				default:
					st_reg <= SSP_IDLE;
			endcase
		end
	end

	// pin history for slave edge detection, inputs already synchronous
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sckp_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			sckp_reg <= sck_i;
			wake_reg <= byte_done && is_slave;
		end
	end

	// ------------------------------------------------------------
	// pins and outputs
	// ------------------------------------------------------------
	// a master drives data out whenever active; only a deselected slave releases it, see sdo_oe
	assign sck_o      = sck_reg;
	assign sck_oe_o   = is_master;
	assign sdo_o      = sdo_reg;
	assign sdo_oe_o   = active && !ss_off;
	assign irq_flag_o = sif_reg;
	assign wake_o     = wake_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_write_collision_flag;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && wr_buf && busy |=> ctrl_reg.write_collision_flag &&
			(shift_reg == ($past(out_ev) ? {$past(shift_reg[6:0]), 1'b0} : $past(shift_reg)));
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged or write taken");

	property p_ovf;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && byte_done && is_slave && bf_reg |=> ctrl_reg.ovf && $stable(rxbuf_reg);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overrun not flagged or byte kept");

	property p_nomov;
		@(posedge mclk_i) disable iff (!nrst_i)
		is_master && !ctrl_reg.ovf |=> !ctrl_reg.ovf;
	endproperty
	a_nomov: assert property (p_nomov) else $error("overflow set in master mode");

	property p_pins;
		@(posedge mclk_i) disable iff (!nrst_i)
		!ctrl_reg.en |-> !sck_oe_o && !sdo_oe_o;
	endproperty
	a_pins: assert property (p_pins) else $error("pins driven while disabled");

	property p_idle;
		@(posedge mclk_i) disable iff (!nrst_i)
		is_master && (st_reg == SSP_IDLE) ##1 is_master && (st_reg == SSP_IDLE)
			|-> sck_o == ctrl_reg.clock_polarity_bit;
	endproperty
	a_idle: assert property (p_idle) else $error("clock idle level wrong");

	property p_start;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && start |=> (st_reg == SSP_RUN) && (hs_reg == 5'h00);
	endproperty
	a_start: assert property (p_start) else $error("master write did not start");

	property p_done;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && byte_done && !(is_slave && bf_reg)
			|=> bf_reg && sif_reg && (rxbuf_reg == $past(rx_byte));
	endproperty
	a_done: assert property (p_done) else $error("completed byte not delivered");

	property p_rd;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && rd_buf && !byte_done |=> !bf_reg;
	endproperty
	a_rd: assert property (p_rd) else $error("buffer read left full flag");

	property p_ss;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && ss_off |-> !sdo_oe_o ##1 (rxcnt_reg == 4'h0);
	endproperty
	a_ss: assert property (p_ss) else $error("select high did not release");

	property p_wake;
		@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && byte_done && is_slave |=> wake_o ##1 (!wake_o || $past(byte_done));
	endproperty
	a_wake: assert property (p_wake) else $error("slave byte gave no wake pulse");

	c_mdone: cover property (@(posedge mclk_i) disable iff (!nrst_i) byte_done && is_master);
	c_sdone: cover property (@(posedge mclk_i) disable iff (!nrst_i) byte_done && is_slave);
	c_ovf:   cover property (@(posedge mclk_i) disable iff (!nrst_i) byte_done && is_slave && bf_reg);
	c_coll:  cover property (@(posedge mclk_i) disable iff (!nrst_i) coll);

endmodule : ssp_spi_port

// *** tb/ssp_peer.sv ***
// far-side spi slave: drives sdi on its drive edge, samples sdo on the other
module ssp_peer
(
	input  wire logic       sck_i,   // serial clock from the port
	input  wire logic       sdo_i,   // data from the port
	input  wire logic       cpol_i,  // idle clock level
	input  wire logic       cke_i,   // one: first bit before any edge
	input  wire logic       start_i, // rising edge loads a new byte
	input  wire logic [7:0] tx_i,    // byte to send, msb first
	output logic            sdi_o,   // data towards the port
	output logic      [7:0] rx_o     // last eight bits captured
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] sh_reg; // outgoing bits; refilled with inverted bits

	initial sdi_o = 1'b0;

	// ----------------------------------------
	// byte load
	// ----------------------------------------
	// without cke the line is not yet valid, so show the inverse
	always @(posedge start_i)
	begin
		sdi_o  = cke_i ? tx_i[7] : ~tx_i[7];
		sh_reg = cke_i ? {tx_i[6:0], ~tx_i[0]} : tx_i;
	end

	// ----------------------------------------
	// shifting on both clock edges
	// ----------------------------------------
	always @(sck_i)
	begin
		if ((sck_i != cpol_i) == cke_i)
			rx_o = {rx_o[6:0], sdo_i};
		else
		begin
			sdi_o  = sh_reg[7];
			sh_reg = {sh_reg[6:0], ~sh_reg[0]};
		end
	end
endmodule : ssp_peer

// *** tb/tb_spi_master_slave_port.sv ***
module tb_spi_master_slave_port;
	import ssp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        mclk_i = 1'b0;  // 10 MHz system clock
	logic        nrst_i = 1'b0;  // reset, active low
	logic        hsel, hwrite, tick, sleep, pst, slv, tb_sck, tb_sdi;
	logic [1:0]  htrans;
	logic [7:0]  haddr, tx, pt, prx;
	logic [31:0] hwdata, hrdata;
	logic [3:0]  m;               // mode field under test
	logic        cp, ck, sp, rd_ph; // polarity, edge bit, sample bit, read data phase
	logic        ss_n = 1'b1;     // slave select towards the port
	logic [7:0]  srx;             // bits the port sent as slave
	wire         hrdy, sck_o, sck_oe, sdo, sdo_oe, irq, wake, psdi;
	wire         sck_pin = sck_oe ? sck_o : tb_sck; // shared clock wire
	wire         sdi_pin = slv ? tb_sdi : psdi;     // who drives data in
	logic [31:0] exp_q[$];        // expected read data, oldest first
	int          n_fail = 0, cmp_count = 0, cyc = 0, n_wake = 0;

	always #50 mclk_i = ~mclk_i;

	ssp_spi_port dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .timer_two_output_tick_i(tick), .sleep_i(sleep),
		.sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe), .sdi_i(sdi_pin), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .ss_n_i(ss_n), .irq_flag_o(irq), .wake_o(wake));

	ssp_peer peer (.sck_i(sck_pin), .sdo_i(sdo), .cpol_i(cp), .cke_i(ck), .start_i(pst), .tx_i(pt),
		.sdi_o(psdi), .rx_o(prx));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic stop_test();
		$display("compares %0d, failures %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	// read data is judged here, against the oldest note
	always @(posedge mclk_i)
		if (rd_ph && hrdy)
			chk(hrdata === exp_q.pop_front(), "read data");

	// cycle count, timer ticks every third cycle, wake pulses, hang guard
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		tick <= (cyc % 3 == 0);
		if (wake === 1'b1)
			n_wake <= n_wake + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	// ----------------------------------------
	// ahb-lite single word transfers
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk_i); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge mclk_i); while (hrdy !== 1'b1);
		rd_ph <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	// testbench as external master: drive on rising, port samples on falling
	task automatic sbyte(input logic [7:0] b, input int n);
		for (int k = 7; k > 7 - n; k--)
		begin
			@(posedge mclk_i);
			tb_sdi <= b[k];
			tb_sck <= 1'b1;
			repeat (4) @(posedge mclk_i);
			srx = {srx[6:0], sdo};
			tb_sck <= 1'b0;
			repeat (3) @(posedge mclk_i);
		end
		tb_sdi <= ~b[0]; // released line must not keep the last bit
		repeat (6) @(posedge mclk_i);
	endtask : sbyte

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{hsel, hwrite, sleep, pst, slv, tb_sck, tb_sdi, rd_ph, cp, ck} = '0;
		{htrans, haddr, hwdata, tick, tx, pt, m} = '0;
		void'($urandom(32'hc007));
		repeat (4) @(posedge mclk_i);
		nrst_i <= 1'b1;
		for (int a = 0; a < 5; a++)
			rd(8'(a * 4), 32'h0);
		// every master rate, random polarity, edge and data
		for (int i = 0; i < 8; i++)
		begin
			m = 4'(i % 4);
			cp = 1'($urandom);
			ck = 1'($urandom);
			sp = 1'($urandom);
			tx = 8'($urandom);
			pt = 8'($urandom);
			tb_sck <= cp;
			wr(SSP_CTRL_OFS, 32'({cp, m}));
			wr(SSP_STAT_OFS, 32'({sp, ck, 6'h0}));
			wr(SSP_FLAG_OFS, 32'h0);
			wr(SSP_CTRL_OFS, 32'({3'b001, cp, m}));
			@(negedge mclk_i);
			chk(sck_o === cp && sck_oe === 1'b1, "idle clock level");
			pst <= 1'b1;
			@(posedge mclk_i);
			pst <= 1'b0;
			wr(SSP_BUF_OFS, 32'(tx));
			wr(SSP_BUF_OFS, 32'(~tx));
			repeat (3000)
			begin
				@(posedge mclk_i);
				if (irq === 1'b1)
					break;
			end
			chk(irq === 1'b1, "interrupt flag");
			rd(SSP_STAT_OFS, 32'({sp, ck, 5'h00, 1'b1}));
			rd(SSP_BUF_OFS, 32'(pt));
			rd(SSP_STAT_OFS, 32'({sp, ck, 5'h00, 1'b0}));
			rd(SSP_CTRL_OFS, 32'({3'b101, cp, m}));
			chk(prx === tx, "byte seen by peer");
		end
		// reserved code leaves the pins alone
		wr(SSP_CTRL_OFS, 32'h06);
		wr(SSP_CTRL_OFS, 32'h26);
		@(negedge mclk_i);
		chk(sck_oe === 1'b0 && sdo_oe === 1'b0, "pins released");
		@(posedge mclk_i);
		// slave without select, asleep, two bytes and no read
		slv <= 1'b1;
		tb_sck <= 1'b0;
		sleep <= 1'b1;
		wr(SSP_CTRL_OFS, 32'h05);
		wr(SSP_STAT_OFS, 32'h0);
		wr(SSP_FLAG_OFS, 32'h0);
		wr(SSP_CTRL_OFS, 32'h25);
		tx = 8'($urandom);
		pt = 8'($urandom);
		wr(SSP_BUF_OFS, 32'(pt));
		sbyte(tx, 8);
		chk(srx === pt, "slave data out");
		sbyte(~tx, 8);
		rd(SSP_CTRL_OFS, 32'h65);
		rd(SSP_BUF_OFS, 32'(tx));
		chk(n_wake == 2, "wake pulses");
		// slave with select: a cut frame is dropped, deselect floats data out
		wr(SSP_CTRL_OFS, 32'h04);
		wr(SSP_CTRL_OFS, 32'h24);
		@(negedge mclk_i);
		chk(sdo_oe === 1'b0, "data out driven while deselected");
		@(posedge mclk_i);
		ss_n <= 1'b0;
		sbyte(~tx, 3);
		ss_n <= 1'b1;
		@(posedge mclk_i);
		ss_n <= 1'b0;
		sbyte(tx, 8);
		rd(SSP_BUF_OFS, 32'(tx));
		repeat (2) @(posedge mclk_i);
		stop_test();
	end
endmodule : tb_spi_master_slave_port
